// *** src/amp_ctrl_consts.vh ***
// Constants of the amplifier control and status register slice.
// Assumes inclusion by bare name from the design file of this block.
`ifndef AMP_CTRL_CONSTS_VH
`define AMP_CTRL_CONSTS_VH

// ****************************************
// Register offsets
// ****************************************
`define ADDR_INTERRUPT_FLAGS 8'h02
`define ADDR_INTERRUPT_MASKS 8'h03
`define ADDR_SYSTEM_CONTROL 8'h04
`define ADDR_SYSTEM_CONTROL_TWO 8'h05
`define ADDR_AUDIO_PORT_CONFIG_ONE 8'h06

// ****************************************
// Reset values and bit masks
// ****************************************
`define RST_INTERRUPT_FLAGS 16'h0000
`define RST_INTERRUPT_MASKS 16'hffff
`define RST_SYSTEM_CONTROL 16'h3343
`define RST_SYSTEM_CONTROL_TWO 16'h0000
`define RST_AUDIO_PORT_CONFIG_ONE 16'h04e8
`define RST_SAMPLE_RATE 4'h8
`define FLAG_IMPLEMENTED 16'hefbf
`define SYSTEM_CONTROL_WRITABLE 16'h7ffb
`define SYSTEM_CONTROL_TWO_WRITABLE 16'h1fff
`define AUDIO_PORT_CONFIG_ONE_WRITABLE 16'h7fff
`define ZERO_WORD 16'h0000

// ****************************************
// Field positions
// ****************************************
`define BIT_UNDERVOLT_FLAG 14
`define BIT_ULTRASOUND_MUTE 14
`define BIT_AGC_DETECTOR 11
`define BIT_AGC_ENABLE 10
`define BIT_DC_CANCEL 9
`define BIT_HW_MUTE 8
`define BIT_RECEIVER_MODE 7
`define BIT_AUDIO_PORT_ENABLE 6
`define BIT_CHANNEL_SWAP 5
`define BIT_BITCLOCK_INVERT 4
`define BIT_PLL_REF 3
`define BIT_AMP_POWERDOWN 1
`define BIT_SYSTEM_POWERDOWN 0
`define BIT_ULTRASONIC_MODE 12
`define BIT_IRQ_DRIVE_MODE 11
`define BIT_IRQ_SOURCE 10
`define VOL_FINE_HI 5
`define VOL_FINE_LO 0
`define VOL_COARSE_HI 9
`define VOL_COARSE_LO 6
`define LEGACY_OUT_HI 14
`define LEGACY_OUT_LO 12
`define CHANNEL_SEL_HI 11
`define CHANNEL_SEL_LO 10
`define FORMAT_HI 9
`define FORMAT_LO 8
`define WIDTH_HI 7
`define WIDTH_LO 6
`define RATIO_HI 5
`define RATIO_LO 4
`define RATE_HI 3
`define RATE_LO 0

// ****************************************
// Encodings
// ****************************************
`define FINE_STEPS_PER_COARSE 10'd48
`define LEGACY_AGC 3'b000
`define LEGACY_TELEMETRY 3'b010
`define LEGACY_SENSE 3'b011
`define CHAN_RESERVED 2'b00
`define CHAN_LEFT 2'b01
`define CHAN_RIGHT 2'b10
`define CHAN_MONO 2'b11
`define FMT_STANDARD 2'b00
`define FMT_MSB 2'b01
`define FMT_LSB 2'b10
`define WIDTH_16 2'b00
`define WIDTH_20 2'b01
`define WIDTH_24 2'b10
`define WIDTH_32 2'b11
`define RATIO_32 2'b00
`define RATIO_48 2'b01
`define RATIO_64 2'b10
`define RATE_LAST_VALID 4'h9
`define BITS_16 6'h10
`define BITS_20 6'h14
`define BITS_24 6'h18
`define BITS_32 6'h20
`define BCLK_32 7'h20
`define BCLK_48 7'h30
`define BCLK_64 7'h40
`define BCLK_NONE 7'h00

`endif

// *** src/amp_system_control_regs.v ***
// Control and status register slice of a digital audio amplifier.
// Assumes a two-wire bus front end that presents byte addresses and
// 16-bit words with one-cycle read and write strobes on this clock.
`include "amp_ctrl_consts.vh"

module amp_system_control_regs
(
   input wire clock,
   input wire rstn,
   input wire [7:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   output reg [15:0] reg_rdata,
   output reg reg_rvalid,
   input wire [15:0] status_in,
   input wire power_on_event,
   output reg irq_pin_out,
   output reg irq_pin_oe_n,
   output reg ultrasound_mute,
   output reg hardware_mute_enable,
   output reg agc_enable,
   output reg agc_detector_select,
   output reg dc_cancel_enable,
   output reg overcurrent_threshold_low,
   output reg audio_port_enable,
   output reg channel_swap,
   output reg bitclock_invert,
   output reg pll_ref_select,
   output reg amp_powerdown,
   output reg system_powerdown,
   output reg ultrasonic_mode,
   output reg [9:0] volume_attenuation,
   output reg [9:0] attenuation_eighth_db,
   output reg [2:0] legacy_out_select,
   output reg legacy_out_reserved,
   output reg [1:0] input_channel_select,
   output reg input_channel_reserved,
   output reg [1:0] audio_format_select,
   output reg audio_format_reserved,
   output reg [5:0] sample_bits,
   output reg [6:0] bitclocks_per_sample,
   output reg [3:0] sample_rate_select,
   output reg sample_rate_reserved
);

   // ****************************************
   // Input synchronisers
   // ****************************************
   reg [15:0] status_meta;
   reg [15:0] status_sync;
   reg power_on_meta;
   reg power_on_sync;

   always @(posedge clock)
   begin
      if (!rstn)
      begin
         status_meta <= `ZERO_WORD;
         status_sync <= `ZERO_WORD;
         power_on_meta <= 1'b0;
         power_on_sync <= 1'b0;
      end
      else
      begin
         status_meta <= status_in;
         status_sync <= status_meta;
         power_on_meta <= power_on_event;
         power_on_sync <= power_on_meta;
      end
   end

   // ****************************************
   // Interrupt flags
   // ****************************************
   reg [15:0] interrupt_flags;
   reg [15:0] live_status;
   reg [15:0] next_flags;
   reg [15:0] flag_events;
   reg flag_read;

   always @*
   begin
      // Reserved status positions never raise a flag
      live_status = status_sync & `FLAG_IMPLEMENTED;
      flag_events = live_status;
      flag_events[`BIT_UNDERVOLT_FLAG] = status_sync[`BIT_UNDERVOLT_FLAG] | power_on_sync;
      flag_read = reg_read && (reg_addr == `ADDR_INTERRUPT_FLAGS);
      // New events win over the clear of a read
      next_flags = (flag_read ? `ZERO_WORD : interrupt_flags) | flag_events;
   end

   always @(posedge clock)
   begin
      if (!rstn)
      begin
         interrupt_flags <= `RST_INTERRUPT_FLAGS;
      end
      else
      begin
         interrupt_flags <= next_flags;
      end
   end

   // ****************************************
   // Register storage
   // ****************************************
   reg [15:0] interrupt_masks;
   reg [15:0] system_control;
   reg [15:0] system_control_two;
   reg [15:0] audio_port_config_one;

   always @(posedge clock)
   begin
      if (!rstn)
      begin
         interrupt_masks <= `RST_INTERRUPT_MASKS;
         system_control <= `RST_SYSTEM_CONTROL;
         system_control_two <= `RST_SYSTEM_CONTROL_TWO;
         audio_port_config_one <= `RST_AUDIO_PORT_CONFIG_ONE;
      end
      else
      begin
         if (reg_write)
         begin
            case (reg_addr)
               `ADDR_INTERRUPT_MASKS:
               begin
                  interrupt_masks <= reg_wdata;
               end
               `ADDR_SYSTEM_CONTROL:
               begin
                  system_control <= reg_wdata & `SYSTEM_CONTROL_WRITABLE;
               end
               `ADDR_SYSTEM_CONTROL_TWO:
               begin
                  system_control_two <= reg_wdata & `SYSTEM_CONTROL_TWO_WRITABLE;
               end
               `ADDR_AUDIO_PORT_CONFIG_ONE:
               begin
                  audio_port_config_one <= reg_wdata & `AUDIO_PORT_CONFIG_ONE_WRITABLE;
               end
               default:
               begin
                  interrupt_masks <= interrupt_masks;
               end
            endcase
         end
      end
   end

   // ****************************************
   // Read port
   // ****************************************
   reg [15:0] read_mux;

   always @*
   begin
      case (reg_addr)
         `ADDR_INTERRUPT_FLAGS: read_mux = interrupt_flags;
         `ADDR_INTERRUPT_MASKS: read_mux = interrupt_masks;
         `ADDR_SYSTEM_CONTROL: read_mux = system_control;
         `ADDR_SYSTEM_CONTROL_TWO: read_mux = system_control_two;
         `ADDR_AUDIO_PORT_CONFIG_ONE: read_mux = audio_port_config_one;
         default: read_mux = `ZERO_WORD;
      endcase
   end

   always @(posedge clock)
   begin
      if (!rstn)
      begin
         reg_rdata <= `ZERO_WORD;
         reg_rvalid <= 1'b0;
      end
      else
      begin
         reg_rvalid <= reg_read;
         if (reg_read)
         begin
            reg_rdata <= read_mux;
         end
      end
   end

   // ****************************************
   // Interrupt pin
   // ****************************************
   reg irq_active;
   reg [15:0] irq_source_bits;

   always @*
   begin
      irq_source_bits = system_control_two[`BIT_IRQ_SOURCE] ?
         live_status : interrupt_flags;
      irq_active = |(irq_source_bits & ~interrupt_masks);
   end

   always @(posedge clock)
   begin
      if (!rstn)
      begin
         irq_pin_out <= 1'b1;
         irq_pin_oe_n <= 1'b1;
      end
      else
      begin
         // Pin is active low; open-drain only drives the low level
         irq_pin_out <= ~irq_active;
         if (system_control_two[`BIT_IRQ_DRIVE_MODE])
         begin
            irq_pin_oe_n <= 1'b0;
         end
         else
         begin
            irq_pin_oe_n <= ~irq_active;
         end
      end
   end

   // ****************************************
   // Control outputs
   // ****************************************
   reg [3:0] vol_coarse;
   reg [5:0] vol_fine;
   reg [9:0] coarse_eighths;
   reg [9:0] next_atten;

   always @*
   begin
      vol_coarse = system_control_two[`VOL_COARSE_HI:`VOL_COARSE_LO];
      vol_fine = system_control_two[`VOL_FINE_HI:`VOL_FINE_LO];
      // One coarse step spans 48 fine steps
      coarse_eighths = {6'h00, vol_coarse} * `FINE_STEPS_PER_COARSE;
      next_atten = coarse_eighths + {4'h0, vol_fine};
   end

   always @(posedge clock)
   begin
      if (!rstn)
      begin
         ultrasound_mute <= 1'b0;
         hardware_mute_enable <= 1'b1;
         agc_enable <= 1'b0;
         agc_detector_select <= 1'b0;
         dc_cancel_enable <= 1'b1;
         overcurrent_threshold_low <= 1'b0;
         audio_port_enable <= 1'b1;
         channel_swap <= 1'b0;
         bitclock_invert <= 1'b0;
         pll_ref_select <= 1'b0;
         amp_powerdown <= 1'b1;
         system_powerdown <= 1'b1;
         ultrasonic_mode <= 1'b0;
         volume_attenuation <= 10'h000;
         attenuation_eighth_db <= 10'h000;
      end
      else
      begin
         ultrasound_mute <= system_control[`BIT_HW_MUTE]
            & system_control[`BIT_ULTRASOUND_MUTE];
         hardware_mute_enable <= system_control[`BIT_HW_MUTE];
         agc_enable <= system_control[`BIT_AGC_ENABLE];
         agc_detector_select <= system_control[`BIT_AGC_DETECTOR];
         dc_cancel_enable <= system_control[`BIT_DC_CANCEL];
         overcurrent_threshold_low <= system_control[`BIT_RECEIVER_MODE];
         audio_port_enable <= system_control[`BIT_AUDIO_PORT_ENABLE];
         channel_swap <= system_control[`BIT_CHANNEL_SWAP];
         bitclock_invert <= system_control[`BIT_BITCLOCK_INVERT];
         pll_ref_select <= system_control[`BIT_PLL_REF];
         // System powerdown also holds the amplifier down
         amp_powerdown <= system_control[`BIT_AMP_POWERDOWN]
            | system_control[`BIT_SYSTEM_POWERDOWN];
         system_powerdown <= system_control[`BIT_SYSTEM_POWERDOWN];
         ultrasonic_mode <= system_control_two[`BIT_ULTRASONIC_MODE];
         volume_attenuation <= system_control_two[`VOL_COARSE_HI:`VOL_FINE_LO];
         attenuation_eighth_db <= next_atten;
      end
   end

   // ****************************************
   // Audio port configuration decode
   // ****************************************
   reg [2:0] cfg_legacy;
   reg [1:0] cfg_chan;
   reg [1:0] cfg_fmt;
   reg [1:0] cfg_width;
   reg [1:0] cfg_ratio;
   reg [3:0] cfg_rate;
   reg next_legacy_reserved;
   reg [5:0] next_bits;
   reg [6:0] next_bclk;

   always @*
   begin
      cfg_legacy = audio_port_config_one[`LEGACY_OUT_HI:`LEGACY_OUT_LO];
      cfg_chan = audio_port_config_one[`CHANNEL_SEL_HI:`CHANNEL_SEL_LO];
      cfg_fmt = audio_port_config_one[`FORMAT_HI:`FORMAT_LO];
      cfg_width = audio_port_config_one[`WIDTH_HI:`WIDTH_LO];
      cfg_ratio = audio_port_config_one[`RATIO_HI:`RATIO_LO];
      cfg_rate = audio_port_config_one[`RATE_HI:`RATE_LO];
      case (cfg_legacy)
         `LEGACY_AGC: next_legacy_reserved = 1'b0;
         `LEGACY_TELEMETRY: next_legacy_reserved = 1'b0;
         `LEGACY_SENSE: next_legacy_reserved = 1'b0;
         default: next_legacy_reserved = 1'b1;
      endcase
      case (cfg_width)
         `WIDTH_16: next_bits = `BITS_16;
         `WIDTH_20: next_bits = `BITS_20;
         `WIDTH_24: next_bits = `BITS_24;
         default: next_bits = `BITS_32;
      endcase
      case (cfg_ratio)
         `RATIO_32: next_bclk = `BCLK_32;
         `RATIO_48: next_bclk = `BCLK_48;
         `RATIO_64: next_bclk = `BCLK_64;
         default: next_bclk = `BCLK_NONE;
      endcase
   end

   always @(posedge clock)
   begin
      if (!rstn)
      begin
         legacy_out_select <= `LEGACY_AGC;
         legacy_out_reserved <= 1'b0;
         input_channel_select <= `CHAN_LEFT;
         input_channel_reserved <= 1'b0;
         audio_format_select <= `FMT_STANDARD;
         audio_format_reserved <= 1'b0;
         sample_bits <= `BITS_32;
         bitclocks_per_sample <= `BCLK_64;
         sample_rate_select <= `RST_SAMPLE_RATE;
         sample_rate_reserved <= 1'b0;
      end
      else
      begin
         legacy_out_select <= cfg_legacy;
         legacy_out_reserved <= next_legacy_reserved;
         input_channel_select <= cfg_chan;
         input_channel_reserved <= (cfg_chan == `CHAN_RESERVED);
         audio_format_select <= cfg_fmt;
         audio_format_reserved <= (cfg_fmt != `FMT_STANDARD) && (cfg_fmt != `FMT_MSB)
            && (cfg_fmt != `FMT_LSB);
         sample_bits <= next_bits;
         bitclocks_per_sample <= next_bclk;
         sample_rate_select <= cfg_rate;
         sample_rate_reserved <= (cfg_rate > `RATE_LAST_VALID);
      end
   end

endmodule // amp_system_control_regs

// *** verification/amp_regs_checker_properties.sv ***
// Port checker for the control register slice.
// Bound to the design top; sees only its ports.
// ****
// Checker
// ****
module amp_regs_checker
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic reg_read,
   input wire logic reg_rvalid,
   input wire logic irq_pin_out,
   input wire logic irq_pin_oe_n,
   input wire logic ultrasound_mute,
   input wire logic hardware_mute_enable,
   input wire logic amp_powerdown,
   input wire logic system_powerdown,
   input wire logic [9:0] volume_attenuation,
   input wire logic [9:0] attenuation_eighth_db,
   input wire logic [2:0] legacy_out_select,
   input wire logic legacy_out_reserved,
   input wire logic [1:0] input_channel_select,
   input wire logic input_channel_reserved,
   input wire logic [1:0] audio_format_select,
   input wire logic audio_format_reserved,
   input wire logic [3:0] sample_rate_select,
   input wire logic sample_rate_reserved
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);
   sequence s_rd_req;
      reg_read;
   endsequence
   sequence s_answer;
      reg_rvalid;
   endsequence
   property p_rd_answer;
      s_rd_req |=> s_answer;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
   property p_us_mute;
      ultrasound_mute |-> hardware_mute_enable;
   endproperty
   a_us_mute: assert property (p_us_mute) else $error("ultrasound mute alone");
   property p_pd;
      system_powerdown |-> amp_powerdown;
   endproperty
   a_pd: assert property (p_pd) else $error("amp on in system powerdown");
   property p_atten;
      attenuation_eighth_db == 10'(volume_attenuation[9:6]) * 10'd48 + 10'(volume_attenuation[5:0]);
   endproperty
   a_atten: assert property (p_atten) else $error("attenuation decode wrong");
   property p_legacy;
      legacy_out_reserved == !(legacy_out_select inside {3'h0, 3'h2, 3'h3});
   endproperty
   a_legacy: assert property (p_legacy) else $error("legacy reserved wrong");
   property p_chan;
      input_channel_reserved == (input_channel_select == 2'h0);
   endproperty
   a_chan: assert property (p_chan) else $error("channel reserved wrong");
   property p_fmt;
      audio_format_reserved == (audio_format_select == 2'h3);
   endproperty
   a_fmt: assert property (p_fmt) else $error("format reserved wrong");
   property p_rate;
      sample_rate_reserved == (sample_rate_select > 4'h9);
   endproperty
   a_rate: assert property (p_rate) else $error("rate reserved wrong");
   property p_od;
      irq_pin_oe_n |-> irq_pin_out;
   endproperty
   a_od: assert property (p_od) else $error("pin released while asserted");
endmodule // amp_regs_checker

bind amp_system_control_regs amp_regs_checker u_chk
(
   .clock(clock), .rstn(rstn), .reg_read(reg_read), .reg_rvalid(reg_rvalid),
   .irq_pin_out(irq_pin_out), .irq_pin_oe_n(irq_pin_oe_n), .ultrasound_mute(ultrasound_mute),
   .hardware_mute_enable(hardware_mute_enable), .amp_powerdown(amp_powerdown),
   .system_powerdown(system_powerdown), .volume_attenuation(volume_attenuation),
   .attenuation_eighth_db(attenuation_eighth_db), .legacy_out_select(legacy_out_select),
   .legacy_out_reserved(legacy_out_reserved), .input_channel_select(input_channel_select),
   .input_channel_reserved(input_channel_reserved), .audio_format_select(audio_format_select),
   .audio_format_reserved(audio_format_reserved), .sample_rate_select(sample_rate_select),
   .sample_rate_reserved(sample_rate_reserved)
);

// *** verification/ctrl_host_model.sv ***
// Host side of the register strobe port.
// Assumes the design takes strobes at the rising edge.
`include "amp_ctrl_consts.vh"
// ****
// Host model
// ****
module ctrl_host_model
(
   input wire logic clock,
   output logic [7:0] reg_addr,
   output logic [15:0] reg_wdata,
   output logic reg_write,
   output logic reg_read,
   input wire logic [15:0] reg_rdata,
   input wire logic reg_rvalid
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      reg_write = 1'b0;
      reg_read = 1'b0;
   end
   task write_word(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask
   task read_word(input logic [7:0] a, output logic [16:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      reg_addr <= ~a;
      #1;
      d = {reg_rvalid, reg_rdata};
   endtask
   // Power-up released only once setup is done
   task finish_config(input logic [15:0] v);
      write_word(`ADDR_SYSTEM_CONTROL, v & 16'hfffc);
   endtask
endmodule // ctrl_host_model

// *** verification/amp_system_control_regs_tb.sv ***
// Testbench of the control register slice.
// Assumes the host model and the bound checker.
// ****
// Testbench
// ****
module amp_system_control_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic [15:0] status_in = 16'h0000;
   logic power_on_event = 1'b0;
   logic [15:0] v;
   logic [16:0] rd;
   logic [2:0] l;
   int fails = 0;
   int n_tests = 0;
   logic [5:0] bits_t [4] = '{6'd16, 6'd20, 6'd24, 6'd32};
   logic [6:0] bclk_t [4] = '{7'd32, 7'd48, 7'd64, 7'd0};
   wire [7:0] reg_addr;
   wire [15:0] reg_wdata, reg_rdata;
   wire reg_write, reg_read, reg_rvalid, irq_pin_out, irq_pin_oe_n, ultrasound_mute;
   wire hardware_mute_enable, agc_enable, agc_detector_select, dc_cancel_enable;
   wire overcurrent_threshold_low, audio_port_enable, channel_swap, bitclock_invert;
   wire pll_ref_select, amp_powerdown, system_powerdown, ultrasonic_mode;
   wire legacy_out_reserved, input_channel_reserved, audio_format_reserved, sample_rate_reserved;
   wire [9:0] volume_attenuation, attenuation_eighth_db;
   wire [2:0] legacy_out_select;
   wire [1:0] input_channel_select, audio_format_select;
   wire [5:0] sample_bits;
   wire [6:0] bitclocks_per_sample;
   wire [3:0] sample_rate_select;
   wire [11:0] ctl_seen = {agc_detector_select, agc_enable, dc_cancel_enable,
      hardware_mute_enable, overcurrent_threshold_low, audio_port_enable, channel_swap,
      bitclock_invert, pll_ref_select, amp_powerdown, system_powerdown, ultrasound_mute};
   always #2 clock = ~clock;
   ctrl_host_model u_host (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
   amp_system_control_regs u_dut (.clock(clock), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .status_in(status_in), .power_on_event(power_on_event),
      .irq_pin_out(irq_pin_out), .irq_pin_oe_n(irq_pin_oe_n), .ultrasound_mute(ultrasound_mute),
      .hardware_mute_enable(hardware_mute_enable), .agc_enable(agc_enable),
      .agc_detector_select(agc_detector_select), .dc_cancel_enable(dc_cancel_enable),
      .overcurrent_threshold_low(overcurrent_threshold_low), .audio_port_enable(audio_port_enable),
      .channel_swap(channel_swap), .bitclock_invert(bitclock_invert),
      .pll_ref_select(pll_ref_select), .amp_powerdown(amp_powerdown),
      .system_powerdown(system_powerdown), .ultrasonic_mode(ultrasonic_mode),
      .volume_attenuation(volume_attenuation), .attenuation_eighth_db(attenuation_eighth_db),
      .legacy_out_select(legacy_out_select), .legacy_out_reserved(legacy_out_reserved),
      .input_channel_select(input_channel_select), .input_channel_reserved(input_channel_reserved),
      .audio_format_select(audio_format_select), .audio_format_reserved(audio_format_reserved),
      .sample_bits(sample_bits), .bitclocks_per_sample(bitclocks_per_sample),
      .sample_rate_select(sample_rate_select), .sample_rate_reserved(sample_rate_reserved));
   task give_verdict;
      if (fails == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task check(input logic [16:0] seen, input logic [16:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         fails++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task rd_chk(input logic [7:0] a, input logic [15:0] exp);
      u_host.read_word(a, rd);
      check(rd, {1'b1, exp});
   endtask
   task idle(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task pulse(input logic [15:0] s, input logic p);
      @(posedge clock);
      status_in <= s;
      power_on_event <= p;
      repeat (6) @(posedge clock);
      status_in <= 16'h0000;
      power_on_event <= 1'b0;
      idle(3);
   endtask
   function automatic logic [11:0] ctl_exp(input logic [15:0] c);
      return {c[11:3], c[1] | c[0], c[0], c[8] & c[14]};
   endfunction
   task chk_cfg(input logic [15:0] c);
      l = c[14:12];
      check(17'({legacy_out_select, legacy_out_reserved}), 17'({l, !(l == 0 || l == 2 || l == 3)}));
      check(17'({input_channel_select, input_channel_reserved}), 17'({c[11:10], c[11:10] == 0}));
      check(17'({audio_format_select, audio_format_reserved}), 17'({c[9:8], c[9:8] == 3}));
      check(17'(sample_bits), 17'(bits_t[c[7:6]]));
      check(17'(bitclocks_per_sample), 17'(bclk_t[c[5:4]]));
      check(17'({sample_rate_select, sample_rate_reserved}), 17'({c[3:0], c[3:0] > 9}));
   endtask
   initial
   begin
      repeat (8) @(posedge clock);
      rstn <= 1'b1;
      rd_chk(8'h02, 16'h0000);
      rd_chk(8'h03, 16'hffff);
      rd_chk(8'h04, 16'h3343);
      rd_chk(8'h05, 16'h0000);
      rd_chk(8'h06, 16'h04e8);
      check(17'(ctl_seen), 17'(ctl_exp(16'h3343)));
      chk_cfg(16'h04e8);
      check(17'({irq_pin_out, irq_pin_oe_n}), 17'h3);
      u_host.write_word(8'h02, 16'hffff);
      rd_chk(8'h02, 16'h0000);
      rd_chk(8'h07, 16'h0000);
      for (int i = 0; i < 17; i++)
      begin
         v = (i == 16) ? 16'h4100 : 16'h0001 << i;
         u_host.write_word(8'h04, v);
         idle(2);
         check(17'(ctl_seen), 17'(ctl_exp(v)));
         rd_chk(8'h04, v & 16'h7ffb);
      end
      u_host.write_word(8'h05, 16'hf3ff);
      idle(2);
      check(17'({ultrasonic_mode, volume_attenuation}), 17'h7ff);
      check(17'(attenuation_eighth_db), 17'h30f);
      rd_chk(8'h05, 16'h13ff);
      u_host.write_word(8'h05, 16'h0040);
      idle(2);
      check(17'(attenuation_eighth_db), 17'd48);
      for (int i = 0; i < 16; i++)
      begin
         v = {1'b0, 3'(i), 2'(i), 2'(i), 2'(i), 2'(i), 4'(i)};
         u_host.write_word(8'h06, v);
         idle(2);
         chk_cfg(v);
         rd_chk(8'h06, v);
      end
      pulse(16'h0008, 1'b0);
      check(17'({irq_pin_out, irq_pin_oe_n}), 17'h3);
      u_host.write_word(8'h03, 16'hfff7);
      idle(3);
      check(17'({irq_pin_out, irq_pin_oe_n}), 17'h0);
      rd_chk(8'h02, 16'h0008);
      rd_chk(8'h02, 16'h0000);
      idle(2);
      check(17'({irq_pin_out, irq_pin_oe_n}), 17'h3);
      u_host.write_word(8'h05, 16'h0800);
      idle(3);
      check(17'({irq_pin_out, irq_pin_oe_n}), 17'h2);
      u_host.write_word(8'h05, 16'h0c00);
      @(posedge clock);
      status_in <= 16'h0008;
      idle(5);
      check(17'({irq_pin_out, irq_pin_oe_n}), 17'h0);
      @(posedge clock);
      status_in <= 16'h0000;
      idle(4);
      check(17'({irq_pin_out, irq_pin_oe_n}), 17'h2);
      rd_chk(8'h02, 16'h0008);
      u_host.write_word(8'h05, 16'h0000);
      pulse(16'h0000, 1'b1);
      rd_chk(8'h02, 16'h4000);
      pulse(16'hffff, 1'b0);
      rd_chk(8'h02, 16'hefbf);
      rd_chk(8'h02, 16'h0000);
      u_host.finish_config(16'h3343);
      idle(2);
      check(17'({amp_powerdown, system_powerdown}), 17'h0);
      give_verdict;
   end
   initial
   begin
      #100000;
      fails++;
      give_verdict;
   end
endmodule // amp_system_control_regs_tb
